// ---- hdl/system_clock_divide_and_stretch.sv ----
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module system_clock_divide_and_stretch
   import clock_divide_pkg::*;
#(
   parameter int MULT_STARTUP_CYCLES = 65536
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   // switchback sources, serial busy and timer 2 baud clock select
   input wire logic extIntQualified,
   input wire logic serialStartBit,
   input wire logic serialTxActive,
   input wire logic serialBusy,
   input wire logic timer2BaudClkOut,
   // external data move request
   input wire logic moveStart,
   input wire logic moveWrite,
   input wire logic pageMiss,
   // clock enables, active mode and stretch count
   output logic machineCycleEn,
   output logic oscClkEn,
   output logic [2:0] timerTickEn,
   output logic [1:0] activeMode,
   output logic [3:0] stretchCycles,
   // memory strobes
   output logic addrStrobe,
   output logic readStrobe_n,
   output logic writeStrobe_n,
   output logic moveBusy,
   output logic moveDone
);

   localparam int STARTUP_W = $clog2(MULT_STARTUP_CYCLES + 1);

   // reset release
   logic rstMeta_reg;
   logic rst_n;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rstMeta_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rst_n <= rstMeta_reg;
      end
   end

   // software state
   logic [1:0] cds_reg;
   logic [1:0] cds_next;
   logic swb_reg;
   logic multEn_reg;
   logic multEn_next;
   logic factor_reg;
   logic factor_next;
   logic [2:0] stretch_reg;
   logic [5:0] timerBase_reg;
   logic multReady_reg;
   logic [STARTUP_W-1:0] startCnt_reg;
   clk_mode_e mode_reg;
   clk_mode_e modeWanted;

   // system clock divider
   logic [11:0] sysCnt_reg;
   logic [11:0] period;
   logic sysTick;
   logic [1:0] oscCnt_reg;
   logic oscTick;

   // decode
   logic wrPower;
   logic wrStretch;
   logic wrTimer;
   logic inDiv1;
   logic inSlow;
   logic switchback;
   logic refuseMult;
   logic refuseSlow;
   logic [1:0] cdsReq;
   logic [7:0] rdMux;

   function automatic logic [3:0] stretch_map(input logic [2:0] sel);
      logic [3:0] r;
      r = {1'b0, sel};
      if (sel[2])
      begin
         r = {2'b00, sel[1:0]} + 4'h7;
      end
      return r;
   endfunction : stretch_map

   function automatic logic [3:0] timer_div(input logic [1:0] sel, input logic fixed2);
      logic [3:0] r;
      r = TDIV_1;
      if (fixed2)
      begin
         r = TDIV_2;
      end
      else if (sel == 2'b00)
      begin
         r = TDIV_12;
      end
      else if (sel == 2'b01)
      begin
         r = TDIV_4;
      end
      return r;
   endfunction : timer_div

   assign wrPower = regWrStb && (regAddr == ADDR_POWER_MODE);
   assign wrStretch = regWrStb && (regAddr == ADDR_STRETCH);
   assign wrTimer = regWrStb && (regAddr == ADDR_TIMER_BASE);

   assign inDiv1 = (cds_reg == CDS_DIV1) || (cds_reg == CDS_RSVD);
   assign inSlow = (mode_reg == MODE_SLOW);

   // only the running slow mode honours switchback; a pending slow code does not
   assign switchback = inSlow && (cds_reg == CDS_SLOW) &&
                       ((swb_reg && (extIntQualified || serialTxActive)) ||
                        serialStartBit);

   assign cdsReq = {regWrData[CDS_HI_POS], regWrData[CDS_LO_POS]};
   assign refuseMult = (cdsReq == CDS_MULT) && !(multEn_next && multReady_reg);
   assign refuseSlow = (cdsReq == CDS_SLOW) && serialBusy;

   // multiplier enable may only move in divide-by-1, factor only while multiplier is off
   assign multEn_next = (wrPower && inDiv1) ? regWrData[MULT_EN_POS] : multEn_reg;
   assign factor_next = (wrPower && !multEn_reg) ? regWrData[FACTOR_POS] : factor_reg;

   always_comb
   begin
      cds_next = cds_reg;
      if (switchback)
      begin
         // hardware switchback wins over a software write in the same cycle
         cds_next = CDS_DIV1;
      end
      else if (wrPower && refuseSlow)
      begin
         cds_next = CDS_DIV1;
      end
      else if (wrPower && !refuseMult)
      begin
         cds_next = cdsReq;
      end
      else if (!multEn_next && cds_reg == CDS_MULT)
      begin
         cds_next = CDS_DIV1;
      end
   end

   always_comb
   begin
      modeWanted = MODE_DIV1;
      if (cds_reg == CDS_SLOW)
      begin
         modeWanted = MODE_SLOW;
      end
      else if (cds_reg == CDS_MULT && multEn_reg && multReady_reg)
      begin
         modeWanted = factor_reg ? MODE_X4 : MODE_X2;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cds_reg <= CDS_RESET;
         swb_reg <= 1'b0;
         multEn_reg <= 1'b0;
         factor_reg <= 1'b0;
      end
      else
      begin
         cds_reg <= cds_next;
         multEn_reg <= multEn_next;
         factor_reg <= factor_next;
         if (wrPower)
         begin
            swb_reg <= regWrData[SWB_POS];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stretch_reg <= STRETCH_RESET;
         timerBase_reg <= TIMER_BASE_RESET;
      end
      else
      begin
         if (wrStretch)
         begin
            stretch_reg <= regWrData[2:0];
         end
         if (wrTimer)
         begin
            timerBase_reg <= regWrData[5:0];
         end
      end
   end

   // multiplier startup timer, restarted on each rising enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         multReady_reg <= 1'b0;
         startCnt_reg <= '0;
      end
      else if (multEn_next && !multEn_reg)
      begin
         multReady_reg <= 1'b0;
         startCnt_reg <= STARTUP_W'(MULT_STARTUP_CYCLES);
      end
      else if (!multEn_reg)
      begin
         multReady_reg <= 1'b0;
         startCnt_reg <= '0;
      end
      else if (startCnt_reg > STARTUP_W'(1))
      begin
         startCnt_reg <= startCnt_reg - STARTUP_W'(1);
      end
      else
      begin
         startCnt_reg <= '0;
         multReady_reg <= 1'b1;
      end
   end

   // system clock enable; period follows the mode latched at the last boundary
   always_comb
   begin
      case (mode_reg)
         MODE_X4: period = PERIOD_X4;
         MODE_X2: period = PERIOD_X2;
         MODE_SLOW: period = PERIOD_SLOW;
         default: period = PERIOD_DIV1;
      endcase
   end

   assign sysTick = (sysCnt_reg >= period);
   assign oscTick = (oscCnt_reg == 2'(OSC_CLK_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sysCnt_reg <= 12'h000;
         oscCnt_reg <= 2'h0;
         mode_reg <= MODE_DIV1;
      end
      else
      begin
         oscCnt_reg <= oscCnt_reg + 2'h1;
         if (sysTick)
         begin
            // a new rate only starts with a fresh cycle, so no pulse is ever cut short
            sysCnt_reg <= 12'h000;
            mode_reg <= modeWanted;
         end
         else
         begin
            sysCnt_reg <= sysCnt_reg + 12'h001;
         end
      end
   end

   // timer time bases
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_timer
         logic [3:0] tcnt_reg;
         logic [3:0] tdiv;
         logic tsrc;
         logic fixed2;

         assign fixed2 = (gi == 2) && timer2BaudClkOut;
         assign tdiv = timer_div(timerBase_reg[2*gi+1 -: 2], fixed2);
         // divide-by-12 stays on oscillator clocks except in slow mode
         assign tsrc = (fixed2 || (timerBase_reg[2*gi+1 -: 2] == 2'b00 && !inSlow)) ?
                       oscTick : sysTick;

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               tcnt_reg <= 4'h0;
               timerTickEn[gi] <= 1'b0;
            end
            else
            begin
               timerTickEn[gi] <= tsrc && (tcnt_reg >= tdiv);
               if (tsrc)
               begin
                  tcnt_reg <= (tcnt_reg >= tdiv) ? 4'h0 : tcnt_reg + 4'h1;
               end
            end
         end
      end
   endgenerate

   // register read
   always_comb
   begin
      rdMux = 8'h00;
      if (regAddr == ADDR_POWER_MODE)
      begin
         rdMux = {cds_reg, swb_reg, multEn_reg, factor_reg, 3'b000};
      end
      else if (regAddr == ADDR_STATUS)
      begin
         rdMux = {5'b00000, mode_reg, multReady_reg};
      end
      else if (regAddr == ADDR_STRETCH)
      begin
         rdMux = {5'b00000, stretch_reg};
      end
      else if (regAddr == ADDR_TIMER_BASE)
      begin
         rdMux = {2'b00, timerBase_reg};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regRdData <= 8'h00;
         machineCycleEn <= 1'b0;
         oscClkEn <= 1'b0;
         activeMode <= MODE_DIV1;
         stretchCycles <= 4'h0;
      end
      else
      begin
         regRdData <= regRdStb ? rdMux : 8'h00;
         machineCycleEn <= sysTick;
         oscClkEn <= oscTick;
         activeMode <= mode_reg;
         stretchCycles <= stretch_map(stretch_reg);
      end
   end

   stretch_sequencer u_seq
   (
      .clk(clk),
      .rst_n(rst_n),
      .sysTick(sysTick),
      .stretchSel(stretch_reg),
      .moveStart(moveStart),
      .moveWrite(moveWrite),
      .pageMiss(pageMiss),
      .addrStrobe(addrStrobe),
      .readStrobe_n(readStrobe_n),
      .writeStrobe_n(writeStrobe_n),
      .moveBusy(moveBusy),
      .moveDone(moveDone)
   );

endmodule : system_clock_divide_and_stretch

// ---- inc/clock_divide_pkg.sv ----
package clock_divide_pkg;

   // register offsets
   localparam logic [3:0] ADDR_POWER_MODE = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_STRETCH = 4'h2;
   localparam logic [3:0] ADDR_TIMER_BASE = 4'h3;

   // power mode register fields
   localparam int CDS_HI_POS = 7;
   localparam int CDS_LO_POS = 6;
   localparam int SWB_POS = 5;
   localparam int MULT_EN_POS = 4;
   localparam int FACTOR_POS = 3;

   // clock divide codes
   localparam logic [1:0] CDS_MULT = 2'h0;
   localparam logic [1:0] CDS_RSVD = 2'h1;
   localparam logic [1:0] CDS_DIV1 = 2'h2;
   localparam logic [1:0] CDS_SLOW = 2'h3;

   typedef enum logic [1:0]
   {
      MODE_X4 = 2'b00,
      MODE_X2 = 2'b01,
      MODE_DIV1 = 2'b10,
      MODE_SLOW = 2'b11
   } clk_mode_e;

   // reset values
   localparam logic [1:0] CDS_RESET = 2'h2;
   localparam logic [5:0] TIMER_BASE_RESET = 6'h00;
   localparam logic [2:0] STRETCH_RESET = 3'h1;

   // system clock periods in clk cycles minus one; one oscillator clock is four clk cycles
   localparam int OSC_CLK_CYCLES = 4;
   localparam logic [11:0] PERIOD_X4 = 12'h000;
   localparam logic [11:0] PERIOD_X2 = 12'h001;
   localparam logic [11:0] PERIOD_DIV1 = 12'h003;
   localparam logic [11:0] PERIOD_SLOW = 12'hfff;

   // timer divisors minus one
   localparam logic [3:0] TDIV_12 = 4'hb;
   localparam logic [3:0] TDIV_4 = 4'h3;
   localparam logic [3:0] TDIV_2 = 4'h1;
   localparam logic [3:0] TDIV_1 = 4'h0;

   // stretch sequencer phase lengths in system clocks
   localparam logic [4:0] ALE_BASE = 5'h02;
   localparam logic [4:0] SETUP_BASE = 5'h02;
   localparam logic [4:0] HOLD_BASE = 5'h02;
   localparam logic [4:0] STRETCH_CLKS = 5'h04;

endpackage : clock_divide_pkg

// ---- hdl/stretch_sequencer.sv ----
`timescale 1ns/1ps
module stretch_sequencer
   import clock_divide_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // timing
   input wire logic sysTick,
   input wire logic [2:0] stretchSel,
   // request
   input wire logic moveStart,
   input wire logic moveWrite,
   input wire logic pageMiss,
   // memory strobes
   output logic addrStrobe,
   output logic readStrobe_n,
   output logic writeStrobe_n,
   output logic moveBusy,
   output logic moveDone
);

   typedef enum logic [2:0]
   {
      S_IDLE = 3'b000,
      S_ALE = 3'b001,
      S_SETUP = 3'b010,
      S_STROBE = 3'b011,
      S_HOLD = 3'b100
   } seq_e;

   seq_e state_reg;
   seq_e state_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic write_reg;
   logic [2:0] sel_reg;
   logic phaseEnd;
   logic [4:0] aleLen;
   logic [4:0] setupLen;
   logic [4:0] strobeLen;
   logic [4:0] holdLen;

   // strobe width is two clocks at code 0, else four per code step
   assign strobeLen = (sel_reg == 3'h0) ? 5'h02 : {sel_reg, 2'b00};
   assign setupLen = (sel_reg == 3'h0) ? SETUP_BASE :
                     (sel_reg[2] ? SETUP_BASE + {STRETCH_CLKS[3:0], 1'b0}
                                 : SETUP_BASE + 5'h01);
   assign holdLen = (sel_reg == 3'h0) ? HOLD_BASE :
                    (sel_reg[2] ? HOLD_BASE + STRETCH_CLKS
                                : HOLD_BASE + 5'h01);
   // the address phase is loaded at start, before the settings are captured
   assign aleLen = (stretchSel[2] && pageMiss) ? ALE_BASE + STRETCH_CLKS : ALE_BASE;
   assign phaseEnd = sysTick && (cnt_reg == 5'h01);

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         S_IDLE:
         begin
            if (moveStart)
            begin
               state_next = S_ALE;
               cnt_next = aleLen;
            end
         end
         S_ALE:
         begin
            if (sysTick && cnt_reg == 5'h01)
            begin
               state_next = S_SETUP;
               cnt_next = setupLen;
            end
            else if (sysTick)
            begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         S_SETUP:
         begin
            if (phaseEnd)
            begin
               state_next = S_STROBE;
               cnt_next = strobeLen;
            end
            else if (sysTick)
            begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         S_STROBE:
         begin
            if (phaseEnd)
            begin
               state_next = S_HOLD;
               cnt_next = holdLen;
            end
            else if (sysTick)
            begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         S_HOLD:
         begin
            if (phaseEnd)
            begin
               state_next = S_IDLE;
               cnt_next = 5'h00;
            end
            else if (sysTick)
            begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         default:
         begin
            state_next = S_IDLE;
            cnt_next = 5'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= S_IDLE;
         cnt_reg <= 5'h00;
         write_reg <= 1'b0;
         sel_reg <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         if (state_reg == S_IDLE && moveStart)
         begin
            // settings are frozen for the whole access so a mid-access write cannot glitch it
            write_reg <= moveWrite;
            sel_reg <= stretchSel;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addrStrobe <= 1'b0;
         readStrobe_n <= 1'b1;
         writeStrobe_n <= 1'b1;
         moveBusy <= 1'b0;
         moveDone <= 1'b0;
      end
      else
      begin
         addrStrobe <= (state_next == S_ALE);
         readStrobe_n <= !(state_next == S_STROBE && !write_reg);
         writeStrobe_n <= !(state_next == S_STROBE && write_reg);
         moveBusy <= (state_next != S_IDLE);
         moveDone <= (state_reg == S_HOLD) && (state_next == S_IDLE);
      end
   end

endmodule : stretch_sequencer

// ---- tb/clock_divide_assertions.sv ----
`timescale 1ns/1ps
module clock_divide_assertions
   import clock_divide_pkg::*;
#(
   parameter int MULT_STARTUP_CYCLES = 65536
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register and serial inputs
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic serialStartBit,
   input wire logic serialBusy,
   // clocking outputs
   input wire logic machineCycleEn,
   input wire logic oscClkEn,
   input wire logic [1:0] activeMode,
   input wire logic [3:0] stretchCycles,
   // memory strobes
   input wire logic addrStrobe,
   input wire logic readStrobe_n,
   input wire logic writeStrobe_n,
   input wire logic moveBusy,
   input wire logic moveDone
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // a slow machine cycle is 4096 clk, beyond a delay range, so the wait is counted
   logic [13:0] swWait;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         swWait <= 14'h0000;
      else if (activeMode == MODE_SLOW && (serialStartBit || swWait != 14'h0000))
         swWait <= swWait + 14'h0001;
      else
         swWait <= 14'h0000;
   end
   stretch_map_a: assert property (
      stretchCycles inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'ha})
      else $error("stretch count outside the code table");
   strobe_busy_a: assert property ((!readStrobe_n || !writeStrobe_n) |-> moveBusy)
      else $error("memory strobe outside a move");
   ale_quiet_a: assert property (addrStrobe |-> readStrobe_n && writeStrobe_n)
      else $error("strobe active during address latch");
   done_pulse_a: assert property (
      moveDone |-> readStrobe_n && !addrStrobe ##1 !moveDone)
      else $error("move done not a clean single pulse");
   mode_edge_a: assert property (
      $changed(activeMode) |-> $past(machineCycleEn) || $past(machineCycleEn, 2))
      else $error("mode changed off a machine cycle boundary");
   osc_period_a: assert property (oscClkEn |=> !oscClkEn [*3] ##1 oscClkEn)
      else $error("oscillator enable not every fourth clock");
   slow_refuse_a: assert property (
      regWrStb && regAddr == ADDR_POWER_MODE && regWrData[7:6] == CDS_SLOW && serialBusy &&
      activeMode != MODE_SLOW |-> ##1 (activeMode != MODE_SLOW) [*8])
      else $error("slow mode entered while serial busy");
   switch_bound_a: assert property (swWait < 14'd4200)
      else $error("no switchback after start bit in slow mode");
endmodule : clock_divide_assertions

bind system_clock_divide_and_stretch clock_divide_assertions
   #(.MULT_STARTUP_CYCLES(MULT_STARTUP_CYCLES)) chkInst (.clk(clk), .arst_n(arst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
   .serialStartBit(serialStartBit), .serialBusy(serialBusy), .machineCycleEn(machineCycleEn),
   .oscClkEn(oscClkEn), .activeMode(activeMode), .stretchCycles(stretchCycles),
   .addrStrobe(addrStrobe), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
   .moveBusy(moveBusy), .moveDone(moveDone));

// ---- tb/mem_model.sv ----
`timescale 1ns/1ps
module mem_model
(
   // strobes from the device
   input wire logic clk,
   input wire logic addrStrobe,
   input wire logic readStrobe_n,
   input wire logic writeStrobe_n,
   // measured phase widths in clk cycles and the direction of the last strobe
   output logic [15:0] aleLen = 16'h0000,
   output logic [15:0] setupLen = 16'h0000,
   output logic [15:0] strobeLen = 16'h0000,
   output logic lastWrite = 1'b0
);
   logic prevAle = 1'b0;
   logic prevStb = 1'b0;
   logic inSetup = 1'b0;
   // falling-edge sampling so registered strobes have settled
   always @(negedge clk)
   begin
      if (addrStrobe)
      begin
         aleLen <= prevAle ? aleLen + 16'h0001 : 16'h0001;
         setupLen <= 16'h0000;
         inSetup <= 1'b1;
      end
      else if (!readStrobe_n || !writeStrobe_n)
      begin
         strobeLen <= prevStb ? strobeLen + 16'h0001 : 16'h0001;
         lastWrite <= !writeStrobe_n;
         inSetup <= 1'b0;
      end
      else if (inSetup)
         setupLen <= setupLen + 16'h0001;
      prevAle <= addrStrobe;
      prevStb <= !readStrobe_n || !writeStrobe_n;
   end
endmodule : mem_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
   import clock_divide_pkg::*;
;
   logic clk = 1'b0, arst_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, regRdData, d;
   logic extInt = 1'b0, startBit = 1'b0, txAct = 1'b0, serBusy = 1'b0, baud = 1'b0;
   logic moveStart = 1'b0, moveWrite = 1'b0, pageMiss = 1'b0;
   logic mcEn, oscEn, aStb, rStb_n, wStb_n, busy, done, lastWr;
   logic [2:0] tick, code;
   logic [1:0] mode;
   logic [3:0] cyc;
   logic [15:0] aleLen, setupLen, strobeLen;
   logic pm, w;
   int errors = 0, compares = 0, i, n, sm;
   // code, page miss, write, mapped stretch count
   logic [8:0] rows [10] = '{{3'h0, 2'b00, 4'h0}, {3'h1, 2'b01, 4'h1}, {3'h2, 2'b00, 4'h2},
      {3'h3, 2'b01, 4'h3}, {3'h4, 2'b00, 4'h7}, {3'h5, 2'b01, 4'h8}, {3'h6, 2'b00, 4'h9},
      {3'h7, 2'b11, 4'ha}, {3'h4, 2'b10, 4'h7}, {3'h0, 2'b10, 4'h0}};
   system_clock_divide_and_stretch #(.MULT_STARTUP_CYCLES(16)) uut (.clk(clk), .arst_n(arst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .extIntQualified(extInt), .serialStartBit(startBit),
      .serialTxActive(txAct), .serialBusy(serBusy), .timer2BaudClkOut(baud),
      .moveStart(moveStart), .moveWrite(moveWrite), .pageMiss(pageMiss), .machineCycleEn(mcEn),
      .oscClkEn(oscEn), .timerTickEn(tick), .activeMode(mode), .stretchCycles(cyc),
      .addrStrobe(aStb), .readStrobe_n(rStb_n), .writeStrobe_n(wStb_n), .moveBusy(busy),
      .moveDone(done));
   mem_model mem (.clk(clk), .addrStrobe(aStb), .readStrobe_n(rStb_n), .writeStrobe_n(wStb_n),
      .aleLen(aleLen), .setupLen(setupLen), .strobeLen(strobeLen), .lastWrite(lastWr));
   always #10 clk = ~clk;
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task final_report();
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      {regAddr, regWrData, regWrStb} <= {a, v, 1'b1};
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk);
      {regAddr, regRdStb} <= {a, 1'b1};
      @(posedge clk);
      regRdStb <= 1'b0;
      // read data stand only in this cycle, so they are taken mid-cycle
      @(negedge clk);
      d = regRdData;
      @(posedge clk);
   endtask : rd
   task waitMode(input logic [1:0] m);
      for (n = 0; n < 6000 && mode !== m; n++) @(negedge clk);
      chk(mode, m);
      @(posedge clk);
   endtask : waitMode
   task spacing(input int idx);
      for (n = 0; n < 500 && tick[idx] !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      for (n = 1; n < 500 && tick[idx] !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
   endtask : spacing
   task resetDut();
      arst_n <= 1'b0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : resetDut
   initial
   begin
      #1200000;
      errors++;
      final_report();
   end
   initial
   begin
      resetDut();
      for (i = 0; i < 10; i++)
      begin
         {code, pm, w} = rows[i][8:4];
         wr(ADDR_STRETCH, {5'h00, code});
         rd(ADDR_STRETCH);
         chk(d[2:0], code);
         // start on a machine cycle boundary so the address phase is whole
         @(posedge clk iff mcEn);
         repeat (2) @(posedge clk);
         {moveStart, moveWrite, pageMiss} <= {1'b1, w, pm};
         @(posedge clk);
         moveStart <= 1'b0;
         for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge clk);
         sm = (code == 3'h0) ? 2 : 4 * code;
         chk(done, 1'b1);
         chk(cyc, rows[i][3:0]);
         chk(strobeLen, 16'(sm * 4));
         chk(aleLen, (code > 3'h3 && pm) ? 16'd24 : 16'd8);
         chk(setupLen, code == 3'h0 ? 16'd8 : (code < 3'h4 ? 16'd12 : 16'd40));
         chk(lastWr, w);
      end
      wr(ADDR_POWER_MODE, 8'h40);
      repeat (20) @(negedge clk);
      chk(mode, MODE_DIV1);
      wr(ADDR_POWER_MODE, 8'h88);
      wr(ADDR_POWER_MODE, 8'h98);
      wr(ADDR_POWER_MODE, 8'h18);
      rd(ADDR_POWER_MODE);
      chk(d[7:6], CDS_DIV1);
      rd(ADDR_STATUS);
      chk(d[0], 1'b0);
      repeat (200) @(posedge clk);
      rd(ADDR_STATUS);
      chk(d[0], 1'b1);
      wr(ADDR_POWER_MODE, 8'h18);
      waitMode(MODE_X4);
      for (n = 0, sm = 0; n < 16; n++) @(negedge clk) sm += mcEn;
      chk(16'(sm), 16'd16);
      spacing(0);
      chk(16'(n), 16'd48);
      {extInt, startBit} <= 2'b11;
      repeat (50) @(negedge clk);
      chk(mode, MODE_X4);
      @(posedge clk);
      {extInt, startBit} <= 2'b00;
      resetDut();
      chk(mode, MODE_DIV1);
      rd(ADDR_POWER_MODE);
      chk(d[7:4], 4'h8);
      rd(ADDR_TIMER_BASE);
      chk(d, TIMER_BASE_RESET);
      wr(4'hf, 8'hff);
      rd(4'hf);
      chk(d, 8'h00);
      spacing(0);
      chk(16'(n), 16'd48);
      baud <= 1'b1;
      spacing(2);
      chk(16'(n), 16'd8);
      serBusy <= 1'b1;
      wr(ADDR_POWER_MODE, 8'hc0);
      rd(ADDR_POWER_MODE);
      chk(d[7:6], CDS_DIV1);
      serBusy <= 1'b0;
      for (i = 0; i < 3; i++)
      begin
         wr(ADDR_POWER_MODE, i == 0 ? 8'hc0 : 8'he0);
         waitMode(MODE_SLOW);
         @(posedge clk);
         {txAct, extInt, startBit} <= 3'b001 << i;
         waitMode(MODE_DIV1);
         {txAct, extInt, startBit} <= 3'b000;
      end
      final_report();
   end
endmodule : tb
